/* verif/charge_timing_profile_config_test.sv */
`include "charge_timing_defs.svh"
module charge_timing_profile_config_test;
  import charge_timing_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 4;   // short ms keeps the run small
  localparam int SETTLE_MS [8] = '{200, 400, 600, 800, 1000, 1200, 1400, 2000};
  logic  clk, nrst, reg_wr, reg_rd, sleep_req;
  logic  mode_select_first, mode_select_second, emulation_master_on;
  byte_t reg_addr, reg_wdata, reg_rdata, standard_profile_enable, older_profile_enable;
  wire   temp_over_reg, discharge_done, device_present, port_switch_request;
  logic  thermal_hold_timer, current_limit_frozen, attach_settle_timer, attach_detect_enable;
  logic  removal_event, attach_event, dedicated_charger_emulation_cycle;
  int    miscompares, comparisons;
  port_env_model env (.clk, .temp_over_reg, .discharge_done, .device_present, .port_switch_request);
  charge_timing_profile_config #(.TICK_CYCLES(TICK)) dut (.clk, .nrst, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .sleep_req, .temp_over_reg, .discharge_done, .device_present,
    .port_switch_request, .mode_select_first, .mode_select_second, .emulation_master_on,
    .thermal_hold_timer, .current_limit_frozen, .attach_settle_timer, .attach_detect_enable,
    .removal_event, .attach_event, .dedicated_charger_emulation_cycle, .standard_profile_enable,
    .older_profile_enable);
  task automatic end_of_test();
    if (miscompares == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask
  // one strobe cycle per access, strobe dropped after its edge
  task automatic wr(input byte_t a, input byte_t d);
    @(posedge clk);
    #1 reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1 reg_wr = 1'b0;
  endtask
  task automatic rdc(input byte_t a, input byte_t exp);
    @(posedge clk);
    #1 reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #1 reg_rd = 1'b0;
    chk(reg_rdata, exp);
  endtask
  // cycles a timer stays up, bounded so a stuck timer ends the run
  task automatic span(input logic s, input int ms);
    int n;
    n = 0;
    while (((s ? attach_settle_timer : thermal_hold_timer) === 1'b1) && n < 9000) begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 9000) begin
      miscompares++;
      end_of_test();
    end else begin
      chk(n >= (ms - 1) * TICK - 3 && n <= ms * TICK + 2, 1'b1);
    end
  endtask
  task automatic t_regs();
    rdc(`TIMING_CFG_ADDR, 8'h03);
    rdc(`STD_PROFILE_ADDR, 8'h16);
    rdc(`OLD_PROFILE_ADDR, 8'h00);
    wr(`TIMING_CFG_ADDR, 8'hff);
    rdc(`TIMING_CFG_ADDR, 8'h1f);
    wr(`OLD_PROFILE_ADDR, 8'hff);
    rdc(`OLD_PROFILE_ADDR, 8'h7f);
    chk(older_profile_enable, 8'h7f);
    wr(8'h22, 8'h5a);
    rdc(8'h22, 8'h00);
  endtask
  task automatic t_profile();
    // reserved field written back as 110
    wr(`STD_PROFILE_ADDR, 8'he6);
    rdc(`STD_PROFILE_ADDR, 8'h06);
    for (int b = 0; b < 2; b++) begin
      wr(`STD_PROFILE_ADDR, b ? 8'h16 : 8'h06);
      for (int m = 0; m < 8; m++) begin
        {emulation_master_on, mode_select_first, mode_select_second} = 3'(m);
        repeat (2) @(posedge clk);
        #1 chk(dedicated_charger_emulation_cycle, m == 6 || b == 0);
      end
    end
    {emulation_master_on, mode_select_first, mode_select_second} = 3'h0;
    chk(standard_profile_enable, 8'h16);
  endtask
  task automatic t_sleep();
    wr(`TIMING_CFG_ADDR, 8'h0d);
    sleep_req = 1'b1;
    repeat (10) @(posedge clk);
    #1 sleep_req = 1'b0;
    rdc(`TIMING_CFG_ADDR, 8'h0d);
    rdc(`STD_PROFILE_ADDR, 8'h16);
    rdc(`OLD_PROFILE_ADDR, 8'h7f);
  endtask
  task automatic t_therm();
    for (int c = 0; c < 4; c++) begin
      wr(8'(c * 8 + 3), 8'(c * 8 + 3));
      wr(`TIMING_CFG_ADDR, 8'(c * 8 + 3));
      env.heat();
      chk(current_limit_frozen, 1'b1);
      span(1'b0, 200 << c);
      chk(current_limit_frozen, 1'b0);
    end
  endtask
  task automatic settle_once(input int c, input logic sw);
    env.place(1'b1, sw);
    wr(`TIMING_CFG_ADDR, 8'(c));
    env.drain();
    chk(removal_event, c > 3 && !sw);
    chk(attach_detect_enable, 1'b0);
    span(1'b1, SETTLE_MS[c]);
    chk({attach_event, attach_detect_enable}, 2'h3);
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    {nrst, reg_wr, reg_rd, sleep_req, reg_addr, reg_wdata} = '0;
    {mode_select_first, mode_select_second, emulation_master_on} = '0;
    {miscompares, comparisons} = '0;
    repeat (20) @(posedge clk);
    #1 nrst = 1'b1;
    t_regs();
    t_profile();
    t_sleep();
    t_therm();
    for (int c = 0; c < 8; c++) settle_once(c, 1'b0);
    settle_once(7, 1'b1);
    end_of_test();
  end
endmodule
bind charge_timing_profile_config timing_cfg_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (.clk, .nrst,
  .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .temp_over_reg, .discharge_done, .device_present,
  .port_switch_request, .thermal_hold_timer, .current_limit_frozen, .attach_settle_timer,
  .attach_detect_enable, .removal_event, .attach_event);

/* verif/port_env_model.sv */
// ----------------------------------------
// die heat and bus discharge source
// ----------------------------------------
module port_env_model (
  input  wire logic clk,
  output logic      temp_over_reg,        // die above threshold
  output logic      discharge_done,       // discharge finished pulse
  output logic      device_present,       // portable device attached
  output logic      port_switch_request   // switch request level
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {temp_over_reg, discharge_done, device_present, port_switch_request} = '0;
  end
  task automatic heat();
    @(posedge clk);
    #1 temp_over_reg = 1'b1;
    repeat (2) @(posedge clk);
    #1 temp_over_reg = 1'b0;
  endtask
  task automatic drain();
    @(posedge clk);
    #1 discharge_done = 1'b1;
    @(posedge clk);
    #1 discharge_done = 1'b0;
  endtask
  // attach state, changed only between frames
  task automatic place(input logic p, input logic s);
    device_present = p;
    port_switch_request = s;
  endtask
endmodule

/* verif/timing_cfg_props.sv */
`include "charge_timing_defs.svh"
// ----------------------------------------
// port level checks
// ----------------------------------------
module timing_cfg_props
  import charge_timing_pkg::*;
#(
  parameter int TICK_CYCLES = `CLK_HZ / `MS_PER_S  // cycles per millisecond
) (
  input wire logic  clk,
  input wire logic  nrst,
  input wire logic  reg_wr,
  input wire logic  reg_rd,
  input wire byte_t reg_addr,
  input wire byte_t reg_wdata,
  input wire byte_t reg_rdata,
  input wire logic  temp_over_reg,
  input wire logic  discharge_done,
  input wire logic  device_present,
  input wire logic  port_switch_request,
  input wire logic  thermal_hold_timer,
  input wire logic  current_limit_frozen,
  input wire logic  attach_settle_timer,
  input wire logic  attach_detect_enable,
  input wire logic  removal_event,
  input wire logic  attach_event
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] sel_reg;   // shadow of the settle select field
  int         hold_len;  // cycles the limit has stood frozen
  int         run_len;   // cycles the settle timer has run
  // run lengths, so an early release shows whatever the selection was
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hold_len <= 0;
      run_len  <= 0;
    end else begin
      hold_len <= current_limit_frozen ? hold_len + 1 : 0;
      run_len  <= attach_settle_timer ? run_len + 1 : 0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // shadow tracks writes so removal can be predicted from ports only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) sel_reg <= 3'h3;
    else if (reg_wr && reg_addr == `TIMING_CFG_ADDR) sel_reg <= reg_wdata[2:0];
  end
  sequence long_go;
    discharge_done && device_present && !port_switch_request && sel_reg > `SETTLE_LONG_CODE;
  endsequence
  sequence short_go;
    discharge_done && (sel_reg <= `SETTLE_LONG_CODE || port_switch_request || !device_present);
  endsequence
  hold_start_a: assert property ($rose(temp_over_reg) |=> thermal_hold_timer) else $error("hold not started");
  limit_follows_a: assert property (current_limit_frozen == thermal_hold_timer) else $error("limit released");
  limit_min_hold_a: assert property ($fell(current_limit_frozen) |-> hold_len >= 199 * TICK_CYCLES)
    else $error("limit released early");
  settle_min_run_a: assert property ($fell(attach_settle_timer) |-> run_len >= 199 * TICK_CYCLES)
    else $error("settle ended early");
  settle_start_a: assert property (discharge_done |=> attach_settle_timer) else $error("settle not started");
  detect_blocked_a: assert property (attach_settle_timer |-> !attach_detect_enable) else $error("detect open");
  long_removal_a: assert property (long_go |=> removal_event) else $error("removal missing");
  short_removal_a: assert property (short_go |=> !removal_event) else $error("removal extra");
  removal_cause_a: assert property (removal_event |-> $past(discharge_done)) else $error("removal unasked");
  attach_end_a: assert property ($fell(attach_settle_timer) && device_present |-> ##[0:1] attach_event)
    else $error("attach missing");
  unmapped_zero_a: assert property (reg_rd && (reg_addr < 8'h1f || reg_addr > 8'h21) |=> reg_rdata == 8'h00)
    else $error("unmapped read");
  spare_zero_a: assert property (reg_rd && reg_addr == `STD_PROFILE_ADDR |=> (reg_rdata & 8'he8) == 8'h00)
    else $error("spare bits");
endmodule

/* verilog/charge_timing_defs.svh */
`ifndef CHARGE_TIMING_DEFS_SVH
`define CHARGE_TIMING_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define TIMING_CFG_ADDR      8'h1f
`define STD_PROFILE_ADDR     8'h20
`define OLD_PROFILE_ADDR     8'h21

// ----------------------------------------
// reset values and writable masks
// ----------------------------------------
`define TIMING_CFG_RESET     8'h03
`define STD_PROFILE_RESET    8'h16
`define OLD_PROFILE_RESET    8'h00
`define TIMING_CFG_MASK      8'h1f
`define STD_PROFILE_MASK     8'h17
`define OLD_PROFILE_MASK     8'h7f

// ----------------------------------------
// field positions
// ----------------------------------------
`define THERM_SEL_HI         4
`define THERM_SEL_LO         3
`define SETTLE_SEL_HI        2
`define SETTLE_SEL_LO        0
`define DCP_OFF_BIT          4

// ----------------------------------------
// timing, in milliseconds
// ----------------------------------------
`define CLK_HZ               25000000
`define MS_PER_S             1000
`define THERM_MS_0           11'd200
`define THERM_MS_1           11'd400
`define THERM_MS_2           11'd800
`define THERM_MS_3           11'd1600
`define SETTLE_MS_0          11'd200
`define SETTLE_MS_1          11'd400
`define SETTLE_MS_2          11'd600
`define SETTLE_MS_3          11'd800
`define SETTLE_MS_4          11'd1000
`define SETTLE_MS_5          11'd1200
`define SETTLE_MS_6          11'd1400
`define SETTLE_MS_7          11'd2000
`define SETTLE_LONG_CODE     3'h3

// ----------------------------------------
// dedicated charging mode select code {emulation on, first, second}
// ----------------------------------------
`define DCP_MODE_CODE        3'h6

`endif

/* verilog/charge_timing_pkg.sv */
package charge_timing_pkg;
  typedef logic [7:0]  byte_t;   // register data
  typedef logic [10:0] ms_t;     // millisecond count
endpackage

/* verilog/charge_timing_profile_config.sv */
// Contract
// RULE1: thermal hold timer starts on overtemperature
// RULE2: reduced limit held until hold timer expires
// RULE3: settle timer after discharge blocks attach detect
// RULE4: long settle, attached, switch off: removal, attach
// RULE5: thermal select codes give 200..1600 ms
// RULE6: settle select codes give 200..2000 ms
// RULE7: timing register kept through sleep
// RULE8: profile enables kept through sleep
// RULE9: dedicated profile off bit skips profile
// RULE10: off bit ignored in dedicated mode
// RULE11: host keeps reserved bits unchanged
// RULE12: unimplemented bits ignore writes, read zero
`include "charge_timing_defs.svh"

module charge_timing_profile_config
  import charge_timing_pkg::*;
#(
  parameter int TICK_CYCLES = `CLK_HZ / `MS_PER_S  // cycles per millisecond
) (
  input  wire logic  clk,
  input  wire logic  nrst,
  input  wire logic  reg_wr,                       // register write strobe
  input  wire logic  reg_rd,                       // register read strobe
  input  wire byte_t reg_addr,                     // register offset
  input  wire byte_t reg_wdata,                    // write data
  output byte_t      reg_rdata,                    // read data
  input  wire logic  sleep_req,                    // sleep state, no effect on settings
  input  wire logic  temp_over_reg,                // die above regulation threshold
  input  wire logic  discharge_done,               // bus discharged, bypass back on
  input  wire logic  device_present,               // portable device attached
  input  wire logic  port_switch_request,          // port switch request
  input  wire logic  mode_select_first,            // mode select input one
  input  wire logic  mode_select_second,           // mode select input two
  input  wire logic  emulation_master_on,          // emulation master enable
  output logic       thermal_hold_timer,           // hold timer running
  output logic       current_limit_frozen,         // reduced limit must stay
  output logic       attach_settle_timer,          // settle timer running
  output logic       attach_detect_enable,         // attach detection allowed
  output logic       removal_event,                // removal report pulse
  output logic       attach_event,                 // attach report pulse
  output logic       dedicated_charger_emulation_cycle, // dedicated profile in cycle
  output byte_t      standard_profile_enable,      // standard profile bits
  output byte_t      older_profile_enable          // older profile bits
);

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("TICK_CYCLES must be at least one");
  end

  // ----------------------------------------
  // register file
  // ----------------------------------------
  byte_t timing_reg;                 // thermal and settle selects
  byte_t std_reg;                    // standard profile enable
  byte_t old_reg;                    // older profile enable
  wire   sel_timing = reg_addr == `TIMING_CFG_ADDR;
  wire   sel_std    = reg_addr == `STD_PROFILE_ADDR;
  wire   sel_old    = reg_addr == `OLD_PROFILE_ADDR;
  byte_t rd_mux;

  // read decode, unmapped offsets read zero
  assign rd_mux = sel_timing ? timing_reg :
                  sel_std    ? std_reg    :
                  sel_old    ? old_reg    : 8'h00;

  // only reset clears settings; sleep is deliberately not a term here
  // RULE7: timing kept through sleep
  // RULE8: profiles kept through sleep
  // RULE12: masks drop unimplemented bits
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      timing_reg <= `TIMING_CFG_RESET;
      std_reg    <= `STD_PROFILE_RESET;
      old_reg    <= `OLD_PROFILE_RESET;
    end else if (reg_wr) begin
      if (sel_timing) begin
        timing_reg <= reg_wdata & `TIMING_CFG_MASK;
      end else if (sel_std) begin
        // reserved low bits stay writable; host must restore them
        // RULE11: host keeps reserved
        std_reg <= reg_wdata & `STD_PROFILE_MASK;
      end else if (sel_old) begin
        old_reg <= reg_wdata & `OLD_PROFILE_MASK;
      end
    end
  end

  // read data registered on the read strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

  // ----------------------------------------
  // millisecond time base
  // ----------------------------------------
  logic [31:0] div_reg;   // cycle divider
  logic        ms_tick;   // one-cycle pulse each ms
  assign ms_tick = div_reg == 32'(TICK_CYCLES - 1);

  // free running divider; timer start phase is off by under one ms
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_reg <= 32'h0;
    end else begin
      div_reg <= ms_tick ? 32'h0 : div_reg + 32'h1;
    end
  end

  // ----------------------------------------
  // select decoding
  // ----------------------------------------
  wire [1:0] therm_sel  = timing_reg[`THERM_SEL_HI:`THERM_SEL_LO];
  wire [2:0] settle_sel = timing_reg[`SETTLE_SEL_HI:`SETTLE_SEL_LO];
  ms_t       therm_ms;
  ms_t       settle_ms;

  // RULE5: thermal hold lookup
  assign therm_ms = (therm_sel == 2'h0) ? `THERM_MS_0 :
                    (therm_sel == 2'h1) ? `THERM_MS_1 :
                    (therm_sel == 2'h2) ? `THERM_MS_2 : `THERM_MS_3;

  // RULE6: settle time lookup
  assign settle_ms = (settle_sel == 3'h0) ? `SETTLE_MS_0 :
                     (settle_sel == 3'h1) ? `SETTLE_MS_1 :
                     (settle_sel == 3'h2) ? `SETTLE_MS_2 :
                     (settle_sel == 3'h3) ? `SETTLE_MS_3 :
                     (settle_sel == 3'h4) ? `SETTLE_MS_4 :
                     (settle_sel == 3'h5) ? `SETTLE_MS_5 :
                     (settle_sel == 3'h6) ? `SETTLE_MS_6 : `SETTLE_MS_7;

  // ----------------------------------------
  // thermal hold timer
  // ----------------------------------------
  logic temp_q;      // previous temperature flag
  ms_t  therm_cnt;   // remaining hold ms
  wire  temp_rise = temp_over_reg & ~temp_q;

  // a new rise restarts the hold from the full time
  // RULE1: start on rise
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      temp_q    <= 1'b0;
      therm_cnt <= 11'h0;
    end else begin
      temp_q <= temp_over_reg;
      if (temp_rise) begin
        therm_cnt <= therm_ms;
      end else if (ms_tick && therm_cnt != 11'h0) begin
        therm_cnt <= therm_cnt - 11'h1;
      end
    end
  end

  // running flags, registered from the counter's next state
  // RULE2: freeze limit while running
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      thermal_hold_timer   <= 1'b0;
      current_limit_frozen <= 1'b0;
    end else begin
      thermal_hold_timer   <= temp_rise | (therm_cnt > 11'h1) | (therm_cnt == 11'h1 && !ms_tick);
      current_limit_frozen <= temp_rise | (therm_cnt > 11'h1) | (therm_cnt == 11'h1 && !ms_tick);
    end
  end

  // ----------------------------------------
  // attach settle timer
  // ----------------------------------------
  ms_t settle_cnt;   // remaining settle ms
  wire settle_end  = ms_tick && settle_cnt == 11'h1;
  wire long_settle = settle_sel > `SETTLE_LONG_CODE;

  // RULE3: settle after discharge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      settle_cnt <= 11'h0;
    end else if (discharge_done) begin
      settle_cnt <= settle_ms;
    end else if (ms_tick && settle_cnt != 11'h0) begin
      settle_cnt <= settle_cnt - 11'h1;
    end
  end

  // detection gated while counting; events are one-cycle pulses
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      attach_settle_timer  <= 1'b0;
      attach_detect_enable <= 1'b1;
      removal_event        <= 1'b0;
      attach_event         <= 1'b0;
    end else begin
      attach_settle_timer  <= discharge_done | (settle_cnt != 11'h0 && !settle_end);
      attach_detect_enable <= ~(discharge_done | (settle_cnt != 11'h0 && !settle_end));
      // RULE4: removal then reattach
      removal_event        <= discharge_done & long_settle & device_present & ~port_switch_request;
      attach_event         <= settle_end & !discharge_done & device_present;
    end
  end

  // ----------------------------------------
  // profile enables
  // ----------------------------------------
  wire dcp_mode = {emulation_master_on, mode_select_first, mode_select_second} == `DCP_MODE_CODE;

  // RULE9: off bit skips profile
  // RULE10: dedicated mode overrides
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dedicated_charger_emulation_cycle <= 1'b0;
      standard_profile_enable           <= 8'h00;
      older_profile_enable              <= 8'h00;
    end else begin
      dedicated_charger_emulation_cycle <= dcp_mode | ~std_reg[`DCP_OFF_BIT];
      standard_profile_enable           <= std_reg;
      older_profile_enable              <= old_reg;
    end
  end

  // sleep leaves every setting untouched
  wire unused_sleep = sleep_req;

endmodule
